// file: include/cpl_pkg.sv
/*
  shared constants for the configuration image preload map: image word
  addresses, image and register field positions, built-in defaults,
  config offsets and the loader state type.
  assumes image words are 16 bits addressed by an 8-bit word index.
*/
package cpl_pkg;
  // ==========================================================
  // image geometry and word addresses
  localparam int IMG_AW = 8;
  localparam int IMG_DW = 16;
  localparam logic [7:0] IMG_F2_REVPI = 8'h4c;
  localparam logic [7:0] IMG_PHY1 = 8'h4e;
  localparam logic [7:0] IMG_PORT0_LO = 8'h50;
  localparam logic [7:0] IMG_PORT_STEP = 8'h02;
  localparam logic [7:0] IMG_F0_CLASS = 8'h58;
  localparam logic [7:0] IMG_F1_CLASS = 8'h5a;
  localparam logic [7:0] IMG_F2_CLASS = 8'h5c;
  localparam logic [7:0] IMG_PHY2 = 8'h5e;
  // ==========================================================
  // field positions inside an image word
  localparam int IMG_NSR_BIT = 0;
  localparam int IMG_AUX_LSB = 1;
  localparam int IMG_WAKE_LSB = 6;
  localparam int IMG_HI_LSB = 8;
  localparam int AUX_W = 3;
  localparam int WAKE_W = 2;
  // ==========================================================
  // field positions inside config registers
  localparam int PMC_AUX_LSB = 22;
  localparam int PMC_D1_BIT = 25;
  localparam int PMC_D2_BIT = 26;
  localparam int PMC_WAKE_LSB = 28;
  localparam int PMD_NSR_BIT = 3;
  localparam int PMD_DATA_LSB = 24;
  localparam int CLS_REV_LSB = 0;
  localparam int CLS_PI_LSB = 8;
  localparam int CLS_SUB_LSB = 16;
  localparam int CLS_BASE_LSB = 24;
  // ==========================================================
  // config offsets and apb windows
  localparam logic [7:0] CFG_CLASS = 8'h08;
  localparam logic [7:0] CFG_PMC = 8'h80;
  localparam logic [7:0] CFG_PMD = 8'h84;
  localparam logic [7:0] CFG_PHY1 = 8'ha0;
  localparam logic [7:0] CFG_PHY2 = 8'ha4;
  localparam int APB_UNIT_LSB = 8;
  localparam logic [3:0] UNIT_FUNC_LAST = 4'h2;
  localparam logic [1:0] UNIT_PORT_HI = 2'h1;
  // ==========================================================
  // built-in defaults, kept when the image lacks a word
  localparam logic [7:0] DEF_REV = 8'h00;
  localparam logic [7:0] DEF_PROGIF = 8'h00;
  localparam logic [7:0] DEF_SUBCLASS = 8'h00;
  localparam logic [7:0] DEF_BASE = 8'h00;
  localparam logic [15:0] DEF_PHY = 16'h0000;
  localparam logic [2:0] DEF_AUX = 3'h0;
  localparam logic [1:0] DEF_WAKE = 2'h0;
  localparam logic DEF_NSR = 1'b0;
  localparam logic [7:0] DEF_PMDATA = 8'h00;
  // ==========================================================
  // loader states, gray along load, settle, ready
  typedef enum logic [1:0]
  {
    ST_LOAD = 2'b00,
    ST_SETTLE = 2'b01,
    ST_READY = 2'b11
  } cpl_state_t;
endpackage : cpl_pkg

// file: include/cpl_img_if.sv
/*
  image word strobe shared by the loader and its field holders.
  assumes valid is only raised while the loader accepts image words.
*/
`timescale 1ns/1ps
interface cpl_img_if;
  // one accepted image word per cycle
  logic valid;
  logic [7:0] addr;
  logic [15:0] data;
  modport src (output valid, output addr, output data);
  modport sink (input valid, input addr, input data);
endinterface : cpl_img_if

// file: design/cpl_func_id.sv
/*
  per-function revision, programming interface and class code word.
  assumes the image strobe only pulses during the load phase.
*/
`timescale 1ns/1ps
module cpl_func_id
  import cpl_pkg::*;
#(
  parameter logic [7:0] CLASS_WORD = IMG_F0_CLASS,
  parameter logic [7:0] REVPI_WORD = IMG_F2_REVPI,
  parameter bit HAS_REVPI = 1'b0
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // image words
  cpl_img_if.sink img,
  // assembled config word at offset 08h
  output logic [31:0] class_word
);
  // ==========================================================
  // decode
  logic [7:0] rev_reg, pi_reg, sub_reg, base_reg;
  wire class_hit = img.valid && (img.addr == CLASS_WORD);
  wire revpi_hit = HAS_REVPI && img.valid && (img.addr == REVPI_WORD);

  // low byte to the lower field, high byte to the upper one
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rev_reg <= DEF_REV;
      pi_reg <= DEF_PROGIF;
      sub_reg <= DEF_SUBCLASS;
      base_reg <= DEF_BASE;
    end
    else
    begin
      if (revpi_hit)
      begin
        rev_reg <= img.data[7:0];
        pi_reg <= img.data[15:8];
      end
      if (class_hit)
      begin
        sub_reg <= img.data[7:0];
        base_reg <= img.data[15:8];
      end
    end
  end

  // word assembly by field position
  always_comb
  begin
    class_word = 32'h0000_0000;
    class_word[CLS_REV_LSB +: 8] = rev_reg;
    class_word[CLS_PI_LSB +: 8] = pi_reg;
    class_word[CLS_SUB_LSB +: 8] = sub_reg;
    class_word[CLS_BASE_LSB +: 8] = base_reg;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  revpi_load_a: assert property (revpi_hit |=> class_word[15:0] == $past(img.data))
    else $error("revision and programming interface not loaded");
  class_load_a: assert property (class_hit |=> class_word[31:16] == $past(img.data))
    else $error("class code not loaded from its image word");
endmodule : cpl_func_id

// file: design/cpl_pm_port.sv
/*
  per-port power-management capability and data words.
  assumes the image strobe only pulses during the load phase.
*/
`timescale 1ns/1ps
module cpl_pm_port
  import cpl_pkg::*;
#(
  parameter logic [7:0] LO_WORD = IMG_PORT0_LO
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // image words
  cpl_img_if.sink img,
  // assembled words at 80h and 84h
  output logic [31:0] pmc_word,
  output logic [31:0] pmd_word,
  output logic no_soft_reset
);
  // ==========================================================
  // decode of this port's word pair
  localparam logic [7:0] HI_WORD = LO_WORD + 8'h01;
  logic [AUX_W-1:0] aux_reg;
  logic [WAKE_W-1:0] wake_reg;
  logic nsr_reg;
  logic [7:0] data_reg;
  wire lo_hit = img.valid && (img.addr == LO_WORD);
  wire hi_hit = img.valid && (img.addr == HI_WORD);

  // image bits 4 and 5 are dropped: d1 and d2 support is fixed
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_reg <= DEF_AUX;
      wake_reg <= DEF_WAKE;
      nsr_reg <= DEF_NSR;
      data_reg <= DEF_PMDATA;
    end
    else
    begin
      if (lo_hit)
      begin
        nsr_reg <= img.data[IMG_NSR_BIT];
        aux_reg <= img.data[IMG_AUX_LSB +: AUX_W];
        wake_reg <= img.data[IMG_WAKE_LSB +: WAKE_W];
      end
      if (hi_hit)
        data_reg <= img.data[IMG_HI_LSB +: 8];
    end
  end

  // word assembly by field position
  always_comb
  begin
    pmc_word = 32'h0000_0000;
    pmc_word[PMC_AUX_LSB +: AUX_W] = aux_reg;
    pmc_word[PMC_D1_BIT] = 1'b1;
    pmc_word[PMC_D2_BIT] = 1'b1;
    pmc_word[PMC_WAKE_LSB +: WAKE_W] = wake_reg;
    pmd_word = 32'h0000_0000;
    pmd_word[PMD_NSR_BIT] = nsr_reg;
    pmd_word[PMD_DATA_LSB +: 8] = data_reg;
  end
  assign no_soft_reset = nsr_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  nsr_load_a: assert property (lo_hit |=> pmd_word[3] == $past(img.data[0]))
    else $error("keep-state bit not loaded");
  aux_load_a: assert property (lo_hit |=> pmc_word[24:22] == $past(img.data[3:1]))
    else $error("standby draw field not loaded");
  d1_fixed_a: assert property (pmc_word[25] == 1'b1)
    else $error("d1 support bit not one");
  d2_fixed_a: assert property (pmc_word[26] == 1'b1)
    else $error("d2 support bit not one");
  wake_load_a: assert property (lo_hit |=> pmc_word[29:28] == $past(img.data[7:6]))
    else $error("wake flags not loaded");
  pmdata_hold_a: assert property (!hi_hit |=> $stable(pmd_word[31:24]))
    else $error("data byte moved without its image word");
  pmdata_load_a: assert property (hi_hit |=> pmd_word[31:24] == $past(img.data[15:8]))
    else $error("data byte not loaded");
endmodule : cpl_pm_port

// file: design/cpl_loader.sv
/*
  configuration image preload map: takes image words during the load
  phase, fills class codes, usb phy controls and per-port power
  management fields, then serves config reads and phy writes over apb.
  assumes the image source presents words synchronous to clock and
  raises img_done once every word it holds has been offered.
*/
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module cpl_loader
  import cpl_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PORTS = 4
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // image source
  input wire logic img_valid,
  input wire logic [IMG_AW-1:0] img_addr,
  input wire logic [IMG_DW-1:0] img_data,
  input wire logic img_done,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status and controls toward the usb side
  output logic load_done,
  output logic [15:0] phy1_ctrl,
  output logic [15:0] phy2_ctrl,
  output logic [PORTS-1:0] no_soft_reset
);
  // ==========================================================
  // loader sequence
  cpl_state_t state_reg, state_next;
  wire loading = (state_reg == ST_LOAD);

  // settle gives the last image word a cycle before reads are served
  // a late img_done only delays readiness; no cycle count is assumed
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_LOAD:
        if (img_done)
          state_next = ST_SETTLE;
      ST_SETTLE:
        state_next = ST_READY;
      ST_READY:
        state_next = ST_READY;
      default:
        state_next = ST_LOAD;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_reg <= ST_LOAD;
    else
      state_reg <= state_next;
  end

  assign load_done = (state_reg == ST_READY);

  // ==========================================================
  // image word strobe, gated so late words are ignored
  cpl_img_if img_bus ();
  assign img_bus.valid = img_valid && loading;
  assign img_bus.addr = img_addr;
  assign img_bus.data = img_data;

  // ==========================================================
  // function identity words
  logic [31:0] class_w [3];

  cpl_func_id #(
    .CLASS_WORD (IMG_F0_CLASS),
    .REVPI_WORD (IMG_F2_REVPI),
    .HAS_REVPI (1'b0)
  ) u_func0 (
    .clock (clock),
    .nrst (nrst),
    .img (img_bus.sink),
    .class_word (class_w[0])
  );

  cpl_func_id #(
    .CLASS_WORD (IMG_F1_CLASS),
    .REVPI_WORD (IMG_F2_REVPI),
    .HAS_REVPI (1'b0)
  ) u_func1 (
    .clock (clock),
    .nrst (nrst),
    .img (img_bus.sink),
    .class_word (class_w[1])
  );

  // only function 2 takes revision and interface from this range
  cpl_func_id #(
    .CLASS_WORD (IMG_F2_CLASS),
    .REVPI_WORD (IMG_F2_REVPI),
    .HAS_REVPI (1'b1)
  ) u_func2 (
    .clock (clock),
    .nrst (nrst),
    .img (img_bus.sink),
    .class_word (class_w[2])
  );

  // ==========================================================
  // per-port power management words
  logic [31:0] pmc_w [PORTS];
  logic [31:0] pmd_w [PORTS];

  // each port decodes its own word pair, two image words apart
  for (genvar i = 0; i < PORTS; i++)
  begin : g_port
    cpl_pm_port #(
      .LO_WORD (8'(IMG_PORT0_LO + IMG_PORT_STEP * i))
    ) u_port (
      .clock (clock),
      .nrst (nrst),
      .img (img_bus.sink),
      .pmc_word (pmc_w[i]),
      .pmd_word (pmd_w[i]),
      .no_soft_reset (no_soft_reset[i])
    );
  end

  // ==========================================================
  // apb address decode
  wire [3:0] unit = paddr[APB_UNIT_LSB +: 4];
  wire [7:0] off = paddr[7:0];
  // units 0 to 2 are functions, 4 to 7 are ports; the rest answer with an error
  wire func_sel = (unit <= UNIT_FUNC_LAST);
  wire port_sel = (unit[3:2] == UNIT_PORT_HI);
  wire [1:0] func_idx = unit[1:0];
  wire [1:0] port_idx = unit[1:0];
  wire hit_class = func_sel && (off == CFG_CLASS);
  wire hit_phy1 = func_sel && (off == CFG_PHY1);
  wire hit_phy2 = func_sel && (off == CFG_PHY2);
  wire hit_pmc = port_sel && (off == CFG_PMC);
  wire hit_pmd = port_sel && (off == CFG_PMD);
  wire hit_any = hit_class || hit_phy1 || hit_phy2 || hit_pmc || hit_pmd;

  // ==========================================================
  // apb handshake: held off until the image is fully applied
  wire apb_access = psel && penable;
  assign pready = apb_access && load_done;
  // pslverr rides on pready, so an unmapped access still ends at once
  assign pslverr = pready && !hit_any;
  wire wr_fire = pready && pwrite;
  wire wr_phy1 = wr_fire && hit_phy1;
  wire wr_phy2 = wr_fire && hit_phy2;

  // ==========================================================
  // phy controls, shared by functions 0 to 2
  logic [15:0] phy1_reg, phy1_next;
  logic [15:0] phy2_reg, phy2_next;
  wire img_phy1 = img_bus.valid && (img_bus.addr == IMG_PHY1);
  wire img_phy2 = img_bus.valid && (img_bus.addr == IMG_PHY2);

  // image and software never collide: writes wait for load_done
  // write data above bit 15 is dropped: the phy controls are 16 bits wide
  assign phy1_next = img_phy1 ? img_bus.data : (wr_phy1 ? pwdata[15:0] : phy1_reg);
  assign phy2_next = img_phy2 ? img_bus.data : (wr_phy2 ? pwdata[15:0] : phy2_reg);

  // phy control registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      phy1_reg <= DEF_PHY;
      phy2_reg <= DEF_PHY;
    end
    else
    begin
      phy1_reg <= phy1_next;
      phy2_reg <= phy2_next;
    end
  end

  assign phy1_ctrl = phy1_reg;
  assign phy2_ctrl = phy2_reg;

  // ==========================================================
  // read data selection, zero for unmapped addresses
  // the hit terms exclude each other, so the priority order is moot
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_class)
      rd_data = class_w[func_idx];
    else if (hit_phy1)
      rd_data = {16'h0000, phy1_reg};
    else if (hit_phy2)
      rd_data = {16'h0000, phy2_reg};
    else if (hit_pmc)
      rd_data = pmc_w[port_idx];
    else if (hit_pmd)
      rd_data = pmd_w[port_idx];
  end

  // registered read data; address is stable from the setup cycle
  // capturing on every psel cycle keeps the access phase free of waits
  logic [31:0] prdata_reg;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prdata_reg <= 32'h0000_0000;
    else if (psel)
      prdata_reg <= rd_data;
  end

  assign prdata = prdata_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // pready only after at least one settle cycle
  ready_gate_a: assert property (pready |-> $past(state_reg) != ST_LOAD)
    else $error("apb answered before image applied");
  settle_walk_a: assert property (
    loading && img_done |=> state_reg == ST_SETTLE ##1 state_reg == ST_READY)
    else $error("load phase did not close in two cycles");
  load_wait_a: assert property (
    loading && !img_done |=> state_reg == ST_LOAD)
    else $error("load phase closed before the image ended");
  done_stays_a: assert property (load_done |=> load_done)
    else $error("load done dropped without reset");

  // ==========================================================
  // checks: image fields freeze once the load phase closes
  late_image_a: assert property (
    !loading |=> $stable(class_w[0]) && $stable(class_w[1]) && $stable(class_w[2]))
    else $error("class word moved after load phase");
  late_port_a: assert property (
    !loading |=> $stable(no_soft_reset))
    else $error("keep-state outputs moved after load phase");
  for (genvar p = 0; p < PORTS; p++)
  begin : g_port_chk
    port_freeze_a: assert property (
      !loading |=> $stable(pmc_w[p]) && $stable(pmd_w[p]))
      else $error("port word moved after load phase");
  end

  // ==========================================================
  // checks: phy controls, image during load, apb after it
  phy1_load_a: assert property (img_phy1 |=> phy1_ctrl == $past(img_data))
    else $error("port 1 phy control not loaded");
  phy2_load_a: assert property (img_phy2 |=> phy2_ctrl == $past(img_data))
    else $error("port 2 phy control not loaded");
  phy_write_a: assert property (wr_phy1 |=> phy1_ctrl == $past(pwdata[15:0]))
    else $error("port 1 phy control write lost");
  phy2_write_a: assert property (wr_phy2 |=> phy2_ctrl == $past(pwdata[15:0]))
    else $error("port 2 phy control write lost");
  phy1_hold_a: assert property (
    !img_phy1 && !wr_phy1 |=> $stable(phy1_ctrl))
    else $error("port 1 phy control moved without a source");
  phy2_hold_a: assert property (
    !img_phy2 && !wr_phy2 |=> $stable(phy2_ctrl))
    else $error("port 2 phy control moved without a source");

  // ==========================================================
  // checks: read data, address held since the setup cycle
  read_class_a: assert property (
    pready && !pwrite && hit_class && $stable(paddr) |-> prdata == class_w[func_idx])
    else $error("class code read mismatch");
  read_phy1_a: assert property (
    pready && !pwrite && hit_phy1 && $stable(paddr) |-> prdata == {16'h0000, phy1_ctrl})
    else $error("port 1 phy control read mismatch");
  read_phy2_a: assert property (
    pready && !pwrite && hit_phy2 && $stable(paddr) |-> prdata == {16'h0000, phy2_ctrl})
    else $error("port 2 phy control read mismatch");
  read_pmc_a: assert property (
    pready && !pwrite && hit_pmc && $stable(paddr) |-> prdata == pmc_w[port_idx])
    else $error("capability word read mismatch");
  read_pmd_a: assert property (
    pready && !pwrite && hit_pmd && $stable(paddr) |-> prdata == pmd_w[port_idx])
    else $error("data word read mismatch");
endmodule : cpl_loader

// file: verification/cpl_img_src.sv
/*
  image source model: offers the image words one slot each, then done,
  then one late word that the loader must drop.
  assumes nrst low restarts the image from its first word.
*/
`timescale 1ns/1ps
module cpl_img_src
#(
  parameter int N = 1,
  parameter int GAP = 0
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // image contents as index and word
  input wire logic [23:0] words [0:N-1],
  input wire logic [23:0] late_word,
  // toward the loader
  output logic img_valid,
  output logic [7:0] img_addr,
  output logic [15:0] img_data,
  output logic img_done
);
  // ====================
  // slot sequencer
  localparam int LAST = N * (GAP + 1);
  int s;
  // idle lines toggle so a stale word never looks stable
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= 0;
      img_valid <= 1'b0;
      img_addr <= 8'h00;
      img_data <= 16'h0000;
      img_done <= 1'b0;
    end
    else
    begin
      if (s < LAST + 8)
        s <= s + 1;
      img_done <= (s >= LAST);
      if ((s < LAST && s % (GAP + 1) == 0) || s == LAST + 4)
      begin
        img_valid <= 1'b1;
        {img_addr, img_data} <= (s < LAST) ? words[s / (GAP + 1)] : late_word;
      end
      else
      begin
        img_valid <= 1'b0;
        img_addr <= ~img_addr;
        img_data <= ~img_data;
      end
    end
  end
endmodule : cpl_img_src

// file: verification/cpl_loader_test.sv
/*
  self-checking bench for the preload map: image model, apb reads.
  assumes unit in paddr[11:8] and config offset in paddr[7:0].
*/
`timescale 1ns/1ps
module cpl_loader_test
  import cpl_pkg::*;
;
  // ====================
  // image contents and expected words
  localparam logic [23:0] IMG [0:13] = '{24'h4c3c12, 24'h4ebeef, 24'h5000ff,
    24'h517700, 24'h520042, 24'h538800, 24'h54008d, 24'h5599ff, 24'h560001,
    24'h580c03, 24'h5a0c04, 24'h5c0c05, 24'h5e1234, 24'h60ffff};
  localparam logic [15:0] LO [0:3] = '{16'h00ff, 16'h0042, 16'h008d, 16'h0001};
  // port 3 data word is absent, so its byte stays default
  localparam logic [15:0] HI [0:3] = '{16'h7700, 16'h8800, 16'h99ff, 16'h0000};
  localparam logic [31:0] CLS [0:2] = '{32'h0c030000, 32'h0c040000, 32'h0c053c12};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, load_done, img_valid, img_done, err;
  logic [15:0] phy1_ctrl, phy2_ctrl, img_data;
  logic [3:0] no_soft_reset;
  logic [7:0] img_addr;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  // ====================
  // design and image source
  cpl_loader dut_u (.clock(clock), .nrst(nrst), .img_valid(img_valid),
    .img_addr(img_addr), .img_data(img_data), .img_done(img_done), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_done(load_done),
    .phy1_ctrl(phy1_ctrl), .phy2_ctrl(phy2_ctrl), .no_soft_reset(no_soft_reset));
  // one idle slot between words exercises a slow source
  cpl_img_src #(.N(14), .GAP(1)) src_u (.clock(clock), .nrst(nrst), .words(IMG),
    .late_word(24'h4e0bad), .img_valid(img_valid), .img_addr(img_addr),
    .img_data(img_data), .img_done(img_done));

  // ====================
  // helpers
  function automatic logic [11:0] ad(input int u, input logic [7:0] off);
    return {u[3:0], off};
  endfunction : ad

  function automatic logic [31:0] pmc_exp(input logic [15:0] w);
    return {2'h0, w[7:6], 1'b0, 2'b11, w[3:1], 22'h0};
  endfunction : pmc_exp

  function automatic logic [31:0] pmd_exp(input logic [15:0] lo, input logic [15:0] hi);
    return {hi[15:8], 20'h0, lo[0], 3'h0};
  endfunction : pmd_exp

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the hang guard ends a wait that never sees pready
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    check(nm, rd, exp);
    check("rd_err", {31'h0, err}, 32'h0);
  endtask : rd_chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // ====================
  // hang guard, well above the 180 or so cycles needed
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ====================
  // test sequence
  initial
  begin
    repeat (12) @(posedge clock);
    check("rst_done", {31'h0, load_done}, 32'h0);
    check("rst_phy", {phy1_ctrl, phy2_ctrl}, 32'h0);
    nrst <= 1'b1;
    // read issued mid-load must wait for the whole image
    rd_chk("f2_class", ad(2, CFG_CLASS), CLS[2]);
    check("done", {31'h0, load_done}, 32'h1);
    $display("test load done");
    repeat (8) @(posedge clock);
    check("phy1", {16'h0, phy1_ctrl}, 32'h0000beef);
    check("phy2", {16'h0, phy2_ctrl}, 32'h00001234);
    check("nsr", {28'h0, no_soft_reset}, 32'hd);
    for (int f = 0; f < 3; f++)
    begin
      rd_chk("class", ad(f, CFG_CLASS), CLS[f]);
      rd_chk("phy1_rd", ad(f, CFG_PHY1), 32'h0000beef);
      rd_chk("phy2_rd", ad(f, CFG_PHY2), 32'h00001234);
    end
    for (int p = 0; p < 4; p++)
    begin
      rd_chk("pmc", ad(4 + p, CFG_PMC), pmc_exp(LO[p]));
      rd_chk("pmd", ad(4 + p, CFG_PMD), pmd_exp(LO[p], HI[p]));
    end
    $display("test map done");
    apb(1'b1, ad(1, CFG_PHY1), 32'hffff5555, rd, err);
    check("wr_err", {31'h0, err}, 32'h0);
    @(posedge clock);
    check("phy1_wr", {16'h0, phy1_ctrl}, 32'h00005555);
    rd_chk("phy1_sh", ad(0, CFG_PHY1), 32'h00005555);
    apb(1'b1, ad(2, CFG_PHY2), 32'h0000a5a5, rd, err);
    check("wr2_err", {31'h0, err}, 32'h0);
    rd_chk("phy2_sh", ad(1, CFG_PHY2), 32'h0000a5a5);
    apb(1'b1, ad(0, CFG_CLASS), 32'hffffffff, rd, err);
    rd_chk("class_ro", ad(0, CFG_CLASS), CLS[0]);
    apb(1'b1, ad(4, CFG_PMC), 32'h0, rd, err);
    rd_chk("pmc_ro", ad(4, CFG_PMC), pmc_exp(LO[0]));
    apb(1'b0, ad(3, CFG_CLASS), 32'h0, rd, err);
    check("unmap_err", {31'h0, err}, 32'h1);
    check("unmap_rd", rd, 32'h0);
    $display("test apb done");
    // second reset mid-run: image reloads and the apb write is lost
    nrst <= 1'b0;
    repeat (12) @(posedge clock);
    check("rst2_phy", {16'h0, phy1_ctrl}, 32'h0);
    nrst <= 1'b1;
    rd_chk("f0_class", ad(0, CFG_CLASS), CLS[0]);
    check("phy1_rl", {16'h0, phy1_ctrl}, 32'h0000beef);
    $display("test reset done");
    finish_test();
  end
endmodule : cpl_loader_test
